//--- logic/smpc_top.sv
// Top of the stop mode power controller: mode tracking, stop entry and wake release.
// Assumes control bits come from software registers on clk_sys and that pins and
// oscillator clock levels are asynchronous; external, power-on and voltage-detection
// resets are combined onto rst_b outside this block.

// Overview of operation
// - Halt request write enters full-stop.
// - Full-stop halts both oscillators and all operation.
// - Contents retained; port latch follows hold select.
// - Timing generator prescaler and divider cleared on entry.
// - Held PC is request address plus two.
// - Reset ends stop; warm-up then single-clock run.
// - Wake pin, key wakeup, voltage detect release.
// - Release select one means level-sensitive release.
// - Release select zero means edge-sensitive release.
// - Level mode releases when wake pin high.
// - Level mode ignores request while pin high.
// - Warm-up never re-enters stop on pin low.
// - Edge mode releases on wake pin rising edge.
// - Edge mode enters stop despite pin high.
// - Warm-up clocks from oscillator used at entry.
// - Low-clock modes run core from four low periods.
// - Dual-clock core on gear, watchdog either clock.
// - Timebase halts exit on selected clock falling edge.
// - Resume in prior mode after warm-up.
// - Restart oscillators, warm-up frozen, then resume.
module smpc_top
  import smpc_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire smpc_ctrl_s           ctrl,
  input  wire logic                 wake_pin,
  input  wire logic                 key_wake_pin,
  input  wire logic                 vd_release_pin,
  input  wire logic                 hf_osc_clk,
  input  wire logic                 lf_osc_clk,
  input  wire logic [SMPC_TB_W-1:0] tb_clk_cand,
  output smpc_stat_s                stat
);

  typedef struct packed {
    smpc_mode_e           mode;
    smpc_mode_e           ret_mode;
    logic                 entry_lf;
    logic                 wake_prev;
    logic                 tb_prev;
    logic                 hf_prev;
    logic                 lf_prev;
    logic [1:0]           mc_cnt;
    logic [SMPC_PC_W-1:0] pc_hold;
    logic                 port_hold;
    smpc_stat_s           stat;
  } smpc_state_s;

  smpc_state_s          st_r;
  smpc_state_s          st_nxt;
  logic [SMPC_SYNC_W-1:0] pins_raw;
  logic [SMPC_SYNC_W-1:0] pins_s;
  logic                 wu_done;
  logic                 hf_tick;
  logic                 lf_tick;

  // True for the modes whose main system clock comes from the low-frequency clock.
  function automatic logic is_low(input smpc_mode_e m);
    is_low = (m == low_clock_run_osc_off) || (m == low_clock_run_osc_on) ||
             (m == low_clock_timebase_halt) || (m == low_clock_cpu_halt);
  endfunction

  // True for the run modes from which a stop request is honoured.
  function automatic logic is_run(input smpc_mode_e m);
    is_run = (m == run_single_clock) || (m == run_dual_clock) ||
             (m == low_clock_run_osc_off) || (m == low_clock_run_osc_on);
  endfunction

  // Every pin and oscillator level is synchronised before any logic looks at it.
  assign pins_raw = {tb_clk_cand, lf_osc_clk, hf_osc_clk, vd_release_pin,
                     key_wake_pin, wake_pin};

  smpc_sync #(
    .W (SMPC_SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // Rising edges of the synchronised oscillator levels act as oscillator ticks.
  assign hf_tick = pins_s[SMPC_SB_HF] && !st_r.hf_prev;
  assign lf_tick = pins_s[SMPC_SB_LF] && !st_r.lf_prev;

  // Warm-up runs only in the warm-up phase, from the clock that fed the core at entry.
  smpc_warmup u_warmup (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .active  (st_r.mode == warmup),
    .tick_hf (hf_tick),
    .tick_lf (lf_tick),
    .use_lf  (st_r.entry_lf),
    .div_sel (ctrl.warmup_div),
    .target  (ctrl.warmup_count_reg),
    .done    (wu_done)
  );

  // Next-state logic: mode transitions, stop entry and release, status decode.
  always_comb begin
    logic tb_sel;
    logic tb_fall;
    logic wake;
    logic wake_rise;
    logic mc_pulse;
    logic release_req;
    tb_sel    = pins_s[SMPC_SB_TB + 32'(ctrl.timebase_clock_select)];
    tb_fall   = st_r.tb_prev && !tb_sel;
    wake      = pins_s[SMPC_SB_WAKE];
    wake_rise = wake && !st_r.wake_prev;
    mc_pulse    = 1'b0;
    release_req = 1'b0;
    st_nxt    = st_r;
    st_nxt.wake_prev = wake;
    st_nxt.tb_prev   = tb_sel;
    st_nxt.hf_prev   = pins_s[SMPC_SB_HF];
    st_nxt.lf_prev   = pins_s[SMPC_SB_LF];
    st_nxt.stat.tg_clear     = 1'b0;
    st_nxt.stat.resume       = 1'b0;
    st_nxt.stat.stop_ignored = 1'b0;

    // Machine cycle: one gear tick, or four low-frequency periods in low-clock modes.
    if (st_r.mode == full_stop || st_r.mode == warmup) begin
      st_nxt.mc_cnt = SMPC_MC_RST;
    end else if (is_low(st_r.mode) || (st_r.mode == stop_arm && st_r.entry_lf)) begin
      if (lf_tick) begin
        if (st_r.mc_cnt == SMPC_MC_LOW_LAST) begin
          st_nxt.mc_cnt = SMPC_MC_RST;
          mc_pulse      = 1'b1;
        end else begin
          st_nxt.mc_cnt = st_r.mc_cnt + 2'h1;
        end
      end
    end else begin
      mc_pulse = hf_tick;
    end
    st_nxt.stat.machine_cycle = mc_pulse;

    // Release sources; the pin's meaning depends on the release mode bit.
    release_req = pins_s[SMPC_SB_KEY] || pins_s[SMPC_SB_VD];
    if (ctrl.release_mode_select) begin
      release_req = release_req || wake;
    end else begin
      release_req = release_req || wake_rise;
    end

    // A stop request from a run mode takes priority over every other transition.
    if (is_run(st_r.mode) && ctrl.halt_req_wr) begin
      if (ctrl.release_mode_select && wake) begin
        st_nxt.stat.stop_ignored = 1'b1;
      end else begin
        st_nxt.mode      = stop_arm;
        st_nxt.ret_mode  = st_r.mode;
        st_nxt.entry_lf  = is_low(st_r.mode);
        st_nxt.pc_hold   = ctrl.request_pc + SMPC_PC_STEP;
        st_nxt.port_hold = ctrl.port_output_hold_select;
      end
    end else begin
      case (st_r.mode)
        run_single_clock: begin
          if (ctrl.lf_osc_enable) begin
            st_nxt.mode = run_dual_clock;
          end else if (ctrl.cpu_halt_req) begin
            st_nxt.mode = cpu_halt_single_clock;
          end else if (ctrl.tb_halt_req) begin
            st_nxt.mode = timebase_only_halt;
          end
        end
        run_dual_clock: begin
          if (!ctrl.lf_osc_enable) begin
            st_nxt.mode = run_single_clock;
          end else if (ctrl.sys_clock_low) begin
            st_nxt.mode = low_clock_run_osc_on;
          end else if (ctrl.cpu_halt_req) begin
            st_nxt.mode = cpu_halt_dual_clock;
          end
        end
        low_clock_run_osc_on: begin
          if (!ctrl.sys_clock_low) begin
            st_nxt.mode = run_dual_clock;
          end else if (!ctrl.hf_osc_enable) begin
            st_nxt.mode = low_clock_run_osc_off;
          end
        end
        low_clock_run_osc_off: begin
          if (ctrl.hf_osc_enable) begin
            st_nxt.mode = low_clock_run_osc_on;
          end else if (ctrl.cpu_halt_req) begin
            st_nxt.mode = low_clock_cpu_halt;
          end else if (ctrl.tb_halt_req) begin
            st_nxt.mode = low_clock_timebase_halt;
          end
        end
        cpu_halt_single_clock: begin
          if (ctrl.irq_release) begin
            st_nxt.mode = run_single_clock;
          end
        end
        cpu_halt_dual_clock: begin
          if (ctrl.irq_release) begin
            st_nxt.mode = run_dual_clock;
          end
        end
        low_clock_cpu_halt: begin
          if (ctrl.irq_release) begin
            st_nxt.mode = low_clock_run_osc_off;
          end
        end
        timebase_only_halt: begin
          if (tb_fall) begin
            st_nxt.mode = run_single_clock;
          end
        end
        low_clock_timebase_halt: begin
          if (tb_fall) begin
            st_nxt.mode = low_clock_run_osc_off;
          end
        end
        stop_arm: begin
          // Oscillators keep running for one machine cycle; in edge mode a pin edge in this
          // window is absorbed by wake_prev and cannot release the stop later.
          if (mc_pulse) begin
            st_nxt.mode          = full_stop;
            st_nxt.stat.tg_clear = 1'b1;
          end
        end
        full_stop: begin
          if (release_req) begin
            st_nxt.mode = warmup;
          end
        end
        warmup: begin
          // The pin is no longer looked at, so a low level cannot restart the stop.
          if (wu_done) begin
            st_nxt.mode          = st_r.ret_mode;
            st_nxt.stat.resume   = 1'b1;
            st_nxt.stat.tg_clear = 1'b1;
          end
        end
        default: begin
          st_nxt.mode = run_single_clock;
        end
      endcase
    end

    // Status decode from the next mode, so every status output is registered.
    st_nxt.stat.mode    = st_nxt.mode;
    st_nxt.stat.pc_hold = st_nxt.pc_hold;
    case (st_nxt.mode)
      full_stop: begin
        st_nxt.stat.hf_osc_on = 1'b0;
        st_nxt.stat.lf_osc_on = 1'b0;
      end
      warmup: begin
        // Restart the oscillators that the prior mode was using.
        st_nxt.stat.hf_osc_on = !is_low(st_nxt.ret_mode) ||
                                (st_nxt.ret_mode == low_clock_run_osc_on);
        st_nxt.stat.lf_osc_on = (st_nxt.ret_mode != run_single_clock);
      end
      stop_arm: begin
        st_nxt.stat.hf_osc_on = !is_low(st_nxt.ret_mode) ||
                                (st_nxt.ret_mode == low_clock_run_osc_on);
        st_nxt.stat.lf_osc_on = (st_nxt.ret_mode != run_single_clock);
      end
      run_single_clock, cpu_halt_single_clock, timebase_only_halt: begin
        st_nxt.stat.hf_osc_on = 1'b1;
        st_nxt.stat.lf_osc_on = 1'b0;
      end
      run_dual_clock, cpu_halt_dual_clock, low_clock_run_osc_on: begin
        st_nxt.stat.hf_osc_on = 1'b1;
        st_nxt.stat.lf_osc_on = 1'b1;
      end
      default: begin
        st_nxt.stat.hf_osc_on = 1'b0;
        st_nxt.stat.lf_osc_on = 1'b1;
      end
    endcase
    st_nxt.stat.cpu_run     = is_run(st_nxt.mode) || (st_nxt.mode == stop_arm);
    st_nxt.stat.cpu_clk_low = is_low(st_nxt.mode);
    st_nxt.stat.wdt_run     = st_nxt.stat.cpu_run;
    st_nxt.stat.wdt_clk_low = is_low(st_nxt.mode) ||
                              ((st_nxt.mode == run_dual_clock) && ctrl.wdt_src_low);
    st_nxt.stat.periph_run  = (st_nxt.mode != full_stop) && (st_nxt.mode != warmup) &&
                              (st_nxt.mode != timebase_only_halt) &&
                              (st_nxt.mode != low_clock_timebase_halt);
    st_nxt.stat.tb_run      = (st_nxt.mode != full_stop) && (st_nxt.mode != warmup);
    // Clocks are gated rather than state reset, so memories and registers keep values.
    st_nxt.stat.state_hold  = (st_nxt.mode == full_stop) || (st_nxt.mode == warmup);
    st_nxt.stat.port_hold   = st_nxt.stat.state_hold && st_nxt.port_hold;
  end

  // State register; after any reset the block starts in warm-up and returns to single-clock run.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r               <= '0;
      st_r.mode          <= warmup;
      st_r.ret_mode      <= run_single_clock;
      st_r.stat.mode     <= warmup;
      st_r.stat.hf_osc_on <= 1'b1;
      st_r.stat.state_hold <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat = st_r.stat;

endmodule

//--- inc/smpc_pkg.sv
// Shared constants and types for the stop mode power controller.
// Assumes a single clk_sys domain and that software-facing bits arrive as plain ports.
package smpc_pkg;

  // Widths of counters and buses.
  localparam int unsigned SMPC_WU_W   = 8;
  localparam int unsigned SMPC_PRE_W  = 8;
  localparam int unsigned SMPC_DIV_W  = 2;
  localparam int unsigned SMPC_PC_W   = 16;
  localparam int unsigned SMPC_TB_W   = 4;
  localparam int unsigned SMPC_SYNC_W = 9;

  // Bit positions inside the synchronised pin vector.
  localparam int unsigned SMPC_SB_WAKE = 0;
  localparam int unsigned SMPC_SB_KEY  = 1;
  localparam int unsigned SMPC_SB_VD   = 2;
  localparam int unsigned SMPC_SB_HF   = 3;
  localparam int unsigned SMPC_SB_LF   = 4;
  localparam int unsigned SMPC_SB_TB   = 5;

  // Program counter step held while stopped, and low clock periods per machine cycle less one.
  localparam logic [SMPC_PC_W-1:0] SMPC_PC_STEP      = 16'h0002;
  localparam logic [1:0]           SMPC_MC_LOW_LAST  = 2'h3;
  localparam logic [1:0]           SMPC_MC_RST       = 2'h0;
  localparam logic [SMPC_PRE_W-1:0] SMPC_PRE_RST     = 8'h00;
  localparam logic [SMPC_WU_W-1:0]  SMPC_WU_RST      = 8'h00;

  // Operating modes, plus the arm, stop and warm-up phases of a stop sequence.
  typedef enum logic [3:0] {
    run_single_clock,
    run_dual_clock,
    low_clock_run_osc_off,
    low_clock_run_osc_on,
    timebase_only_halt,
    cpu_halt_single_clock,
    cpu_halt_dual_clock,
    low_clock_timebase_halt,
    low_clock_cpu_halt,
    stop_arm,
    full_stop,
    warmup
  } smpc_mode_e;

  // Software control bits of the system control registers and neighbours.
  typedef struct packed {
    logic                  halt_req_wr;
    logic                  release_mode_select;
    logic                  port_output_hold_select;
    logic                  lf_osc_enable;
    logic                  hf_osc_enable;
    logic                  sys_clock_low;
    logic                  cpu_halt_req;
    logic                  tb_halt_req;
    logic                  irq_release;
    logic                  wdt_src_low;
    logic [1:0]            timebase_clock_select;
    logic [SMPC_DIV_W-1:0] warmup_div;
    logic [SMPC_WU_W-1:0]  warmup_count_reg;
    logic [SMPC_PC_W-1:0]  request_pc;
  } smpc_ctrl_s;

  // Registered status seen by the rest of the chip.
  typedef struct packed {
    smpc_mode_e           mode;
    logic                 hf_osc_on;
    logic                 lf_osc_on;
    logic                 cpu_run;
    logic                 cpu_clk_low;
    logic                 wdt_run;
    logic                 wdt_clk_low;
    logic                 tb_run;
    logic                 periph_run;
    logic                 state_hold;
    logic                 port_hold;
    logic                 tg_clear;
    logic                 machine_cycle;
    logic                 resume;
    logic                 stop_ignored;
    logic [SMPC_PC_W-1:0] pc_hold;
  } smpc_stat_s;

endpackage

//--- logic/smpc_sync.sv
// Two flip-flop synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; multi-bit coherence is not provided.
module smpc_sync
  import smpc_pkg::*;
#(
  parameter int unsigned W = SMPC_SYNC_W
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smpc_sync_s;

  smpc_sync_s st_r;
  smpc_sync_s st_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

//--- logic/smpc_warmup.sv
// Warm-up counter with a power-of-two prescaler on the chosen oscillator tick.
// Assumes ticks are one-cycle pulses on clk_sys; the counter clears whenever inactive.
module smpc_warmup
  import smpc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  active,
  input  wire logic                  tick_hf,
  input  wire logic                  tick_lf,
  input  wire logic                  use_lf,
  input  wire logic [SMPC_DIV_W-1:0] div_sel,
  input  wire logic [SMPC_WU_W-1:0]  target,
  output logic                       done
);

  typedef struct packed {
    logic [SMPC_PRE_W-1:0] pre;
    logic [SMPC_WU_W-1:0]  cnt;
    logic                  done;
  } smpc_wu_s;

  smpc_wu_s st_r;
  smpc_wu_s st_nxt;

  // Last prescaler value for a divide by two to the power of the select.
  function automatic logic [SMPC_PRE_W-1:0] pre_last(input logic [SMPC_DIV_W-1:0] sel);
    logic [SMPC_PRE_W-1:0] one;
    one      = 8'h01;
    pre_last = (one << sel) - one;
  endfunction

  // Count divided ticks of the entry oscillator until the loaded value is reached.
  always_comb begin
    logic tick;
    tick   = use_lf ? tick_lf : tick_hf;
    st_nxt = st_r;
    if (!active) begin
      st_nxt = '0;
    end else begin
      if (tick && !st_r.done) begin
        if (st_r.pre >= pre_last(div_sel)) begin
          st_nxt.pre = SMPC_PRE_RST;
          st_nxt.cnt = st_r.cnt + 8'h01;
        end else begin
          st_nxt.pre = st_r.pre + 8'h01;
        end
      end
      st_nxt.done = (st_r.cnt >= target);
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

endmodule

//--- test/smpc_top_sva.sv
// Port-level checker for the stop mode power controller.
// Assumes one clk_sys domain and the top module's ports as its only view.
module smpc_top_sva
  import smpc_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst_b,
  input wire smpc_ctrl_s           ctrl,
  input wire logic                 wake_pin,
  input wire logic                 key_wake_pin,
  input wire logic                 vd_release_pin,
  input wire logic                 hf_osc_clk,
  input wire logic                 lf_osc_clk,
  input wire logic [SMPC_TB_W-1:0] tb_clk_cand,
  input wire smpc_stat_s           stat
);
  timeunit 1ns;
  timeprecision 100ps;
  logic in_run;
  logic hold_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // A request only counts in a run mode, so the decode mirrors that window.
  assign in_run = stat.mode inside {run_single_clock, run_dual_clock,
                                    low_clock_run_osc_off, low_clock_run_osc_on};

  // Remember the hold select taken with the last request, to compare during stop.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hold_r <= 1'b0;
    else if (ctrl.halt_req_wr && in_run) hold_r <= ctrl.port_output_hold_select;
  end

  a_req_answer: assert property (ctrl.halt_req_wr && in_run |=>
    stat.mode == stop_arm || stat.stop_ignored) else $error("stop request unanswered");
  a_edge_enter: assert property (ctrl.halt_req_wr && in_run && !ctrl.release_mode_select
    |=> stat.mode == stop_arm) else $error("edge mode request not taken");
  a_refuse_level: assert property (stat.stop_ignored |->
    $past(ctrl.release_mode_select) && stat.mode == $past(stat.mode)) else $error("bad refusal");
  a_pc_step: assert property ($rose(stat.mode == stop_arm) |->
    stat.pc_hold == $past(ctrl.request_pc) + SMPC_PC_STEP) else $error("held address wrong");
  a_stop_quiet: assert property (stat.mode == full_stop |-> !stat.hf_osc_on &&
    !stat.lf_osc_on && !stat.cpu_run && !stat.wdt_run && !stat.tb_run && !stat.periph_run &&
    stat.state_hold) else $error("activity during stop");
  a_entry_clear: assert property ($rose(stat.mode == full_stop) |-> stat.tg_clear)
    else $error("no clear on stop entry");
  a_port_latch: assert property (stat.mode == full_stop |-> stat.port_hold == hold_r)
    else $error("port hold differs from select");
  a_level_wake: assert property ((stat.mode == full_stop && ctrl.release_mode_select &&
    wake_pin) [*3] |-> ##[0:2] stat.mode == warmup) else $error("level wake ignored");
  a_edge_wake: assert property ((stat.mode == full_stop && !ctrl.release_mode_select &&
    $rose(wake_pin)) ##1 wake_pin [*2] |-> ##[0:2] stat.mode == warmup)
    else $error("edge wake ignored");
  a_no_restop: assert property (stat.mode == warmup |=>
    stat.mode != full_stop && stat.mode != stop_arm) else $error("stop re-entered");
  a_resume_pulse: assert property (stat.resume |-> $past(stat.mode) == warmup &&
    !stat.state_hold && stat.tg_clear) else $error("bad resume");
  a_low_core: assert property (stat.mode inside {low_clock_run_osc_off,
    low_clock_run_osc_on} |-> stat.cpu_clk_low) else $error("low mode core clock wrong");
  a_dual_core: assert property (stat.mode == run_dual_clock |->
    !stat.cpu_clk_low && stat.hf_osc_on) else $error("dual mode core clock wrong");

  c_refused: cover property (stat.stop_ignored);
  c_woken: cover property ($rose(stat.mode == warmup));
  c_resumed: cover property (stat.resume);
  c_low: cover property (stat.mode == low_clock_run_osc_off);
endmodule

bind smpc_top smpc_top_sva u_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .ctrl(ctrl), .wake_pin(wake_pin),
  .key_wake_pin(key_wake_pin), .vd_release_pin(vd_release_pin), .hf_osc_clk(hf_osc_clk),
  .lf_osc_clk(lf_osc_clk), .tb_clk_cand(tb_clk_cand), .stat(stat));

//--- test/smpc_wake_src.sv
// Model of the external wake source that drives the wake pin.
// Assumes the bench commands levels on clk_sys and sees the halt request strobe.
module smpc_wake_src
  import smpc_pkg::*;
#(
  parameter int unsigned GUARD = 140
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic halt_seen,
  input  wire logic want_high,
  input  wire logic allow_early,
  output logic      wake_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] guard_r;

  // The guard spans the longest machine cycle, so a polite source never rises too early.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      guard_r  <= 8'h00;
      wake_pin <= 1'b0;
    end else begin
      if (halt_seen) guard_r <= 8'(GUARD);
      else if (guard_r != 8'h00) guard_r <= guard_r - 8'h01;
      if (!want_high) wake_pin <= 1'b0;
      else if ((guard_r == 8'h00 && !halt_seen) || allow_early) wake_pin <= 1'b1;
    end
  end
endmodule

//--- test/smpc_top_tb.sv
// Self-checking bench for the stop mode power controller.
// Assumes the bound checker and a wake source model; oscillators come from a counter.
module smpc_top_tb
  import smpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WU_N = 4;
  localparam int HF_P = 16;
  localparam int LF_P = 32;
  logic       clk_sys = 1'b0;
  logic       rst_b;
  smpc_ctrl_s ctrl;
  smpc_stat_s stat;
  logic       wake_pin, key_pin, vd_pin, want, early;
  logic [8:0] osc_cnt = 9'h000;
  int         fail_count = 0;
  int         n_checks = 0;
  int         n;

  always #2.5 clk_sys = ~clk_sys;
  // Slow oscillator levels, each staying put for many system cycles.
  always @(posedge clk_sys) osc_cnt <= osc_cnt + 9'h001;

  smpc_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ctrl(ctrl), .wake_pin(wake_pin),
    .key_wake_pin(key_pin), .vd_release_pin(vd_pin), .hf_osc_clk(osc_cnt[3]),
    .lf_osc_clk(osc_cnt[4]), .tb_clk_cand(osc_cnt[8:5]), .stat(stat));
  smpc_wake_src u_wake (.clk_sys(clk_sys), .rst_b(rst_b), .halt_seen(ctrl.halt_req_wr),
    .want_high(want), .allow_early(early), .wake_pin(wake_pin));

  task automatic end_sim;
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits on falling edges, where outputs are settled, and reports cycles spent.
  task automatic wait_mode(input smpc_mode_e m, input int lim, output int k);
    k = 0;
    while (stat.mode !== m && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    check(stat.mode, m);
  endtask

  task automatic pulse_gap(output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (stat.machine_cycle !== 1'b1 && k < 300);
  endtask

  // Tick phase is unknown, so a warm-up may be up to one period short or a few cycles long.
  task automatic chk_warm(input int k, input int p);
    check({31'h0, k >= (WU_N - 1) * p && k <= WU_N * p + 6}, 32'h1);
  endtask

  task automatic request(input logic [15:0] pc);
    @(posedge clk_sys);
    ctrl.halt_req_wr <= 1'b1;
    ctrl.request_pc <= pc;
    @(posedge clk_sys);
    ctrl.halt_req_wr <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic t_edge;
    @(posedge clk_sys);
    ctrl.port_output_hold_select <= 1'b1;
    want <= 1'b1;
    repeat (6) @(posedge clk_sys);
    request(16'hfffe);
    check(stat.mode, stop_arm);
    check(stat.pc_hold, 16'h0000);
    wait_mode(full_stop, 40, n);
    check({stat.hf_osc_on, stat.lf_osc_on, stat.port_hold}, 3'b001);
    repeat (30) @(negedge clk_sys);
    check(stat.mode, full_stop);
    @(posedge clk_sys) want <= 1'b0;
    repeat (8) @(posedge clk_sys);
    want <= 1'b1;
    wait_mode(warmup, 200, n);
    wait_mode(run_single_clock, 200, n);
    chk_warm(n, HF_P);
  endtask

  task automatic t_level;
    @(posedge clk_sys);
    ctrl.release_mode_select <= 1'b1;
    ctrl.port_output_hold_select <= 1'b0;
    request(16'h0100);
    check({stat.stop_ignored, stat.mode}, {1'b1, run_single_clock});
    @(posedge clk_sys) want <= 1'b0;
    repeat (6) @(posedge clk_sys);
    request(16'h0100);
    wait_mode(full_stop, 40, n);
    check(stat.port_hold, 1'b0);
    @(posedge clk_sys) want <= 1'b1;
    wait_mode(warmup, 300, n);
    @(posedge clk_sys) want <= 1'b0;
    wait_mode(run_single_clock, 200, n);
  endtask

  // An edge inside the first machine cycle is commanded on purpose and must be ignored.
  task automatic t_early;
    @(posedge clk_sys);
    ctrl.release_mode_select <= 1'b0;
    early <= 1'b1;
    pulse_gap(n);
    @(posedge clk_sys);
    ctrl.halt_req_wr <= 1'b1;
    want <= 1'b1;
    @(posedge clk_sys) ctrl.halt_req_wr <= 1'b0;
    wait_mode(full_stop, 40, n);
    repeat (30) @(negedge clk_sys);
    check(stat.mode, full_stop);
    @(posedge clk_sys) key_pin <= 1'b1;
    wait_mode(warmup, 20, n);
    @(posedge clk_sys) key_pin <= 1'b0;
    wait_mode(run_single_clock, 200, n);
    request(16'h0200);
    wait_mode(full_stop, 40, n);
    @(posedge clk_sys) vd_pin <= 1'b1;
    wait_mode(warmup, 20, n);
    @(posedge clk_sys) vd_pin <= 1'b0;
    wait_mode(run_single_clock, 200, n);
  endtask

  task automatic t_low;
    @(posedge clk_sys);
    ctrl.lf_osc_enable <= 1'b1;
    ctrl.sys_clock_low <= 1'b1;
    ctrl.hf_osc_enable <= 1'b0;
    early <= 1'b0;
    want <= 1'b0;
    wait_mode(low_clock_run_osc_off, 400, n);
    check({stat.cpu_clk_low, stat.wdt_clk_low}, 2'b11);
    pulse_gap(n);
    pulse_gap(n);
    check(n, 4 * LF_P);
    request(16'h0300);
    wait_mode(full_stop, 200, n);
    @(posedge clk_sys) want <= 1'b1;
    wait_mode(warmup, 300, n);
    wait_mode(low_clock_run_osc_off, 300, n);
    chk_warm(n, LF_P);
    request(16'h0400);
    wait_mode(full_stop, 200, n);
    @(posedge clk_sys);
    ctrl.lf_osc_enable <= 1'b0;
    ctrl.sys_clock_low <= 1'b0;
    ctrl.hf_osc_enable <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_mode(run_single_clock, 200, n);
  endtask

  // Timebase halt may only end on a falling candidate edge, so that level is low at exit.
  task automatic t_halt;
    @(posedge clk_sys) ctrl.tb_halt_req <= 1'b1;
    wait_mode(timebase_only_halt, 4, n);
    @(posedge clk_sys) ctrl.tb_halt_req <= 1'b0;
    wait_mode(run_single_clock, 80, n);
    check(osc_cnt[5], 1'b0);
  endtask

  // A hang is cut short well beyond the fifteen hundred or so cycles the tests need.
  initial begin
    repeat (8000) @(posedge clk_sys);
    fail_count++;
    end_sim;
  end

  initial begin
    ctrl = '0;
    ctrl.hf_osc_enable = 1'b1;
    ctrl.warmup_count_reg = 8'h04;
    rst_b = 1'b0;
    {key_pin, vd_pin, want, early} = 4'h0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    check({stat.mode, stat.hf_osc_on, stat.state_hold, stat.pc_hold}, {warmup, 18'h30000});
    @(posedge clk_sys) rst_b <= 1'b1;
    wait_mode(run_single_clock, 200, n);
    chk_warm(n, HF_P);
    t_edge;
    t_level;
    t_early;
    t_low;
    t_halt;
    end_sim;
  end
endmodule
